// >>> hw/piocip_pkg.sv
// Constants for the pin I/O change-interrupt port
package piocip_pkg;
   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int NLINES   = 9;
   localparam int NLOW     = 8;
   localparam int AW       = 16;
   localparam int DW       = 32;
   localparam int IW       = 14;
   localparam int L8       = 8;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [IW-1:0] IDX_DIR_LOW   = 14'h2004;
   localparam logic [IW-1:0] IDX_DATA_LOW  = 14'h2005;
   localparam logic [IW-1:0] IDX_INTEN_LOW = 14'h2006;
   localparam logic [IW-1:0] IDX_FLAG_LOW  = 14'h2007;
   localparam logic [IW-1:0] IDX_SELECT    = 14'h2010;
   localparam logic [IW-1:0] IDX_DATA_L8   = 14'h2011;
   localparam logic [IW-1:0] IDX_DIR_L8    = 14'h2012;
   localparam logic [IW-1:0] IDX_INTEN_L8  = 14'h2013;
   localparam logic [IW-1:0] IDX_FLAG_L8   = 14'h2014;
   localparam logic [IW-1:0] IDX_IRQFLAGS  = 14'h2015;
   localparam logic [IW-1:0] IDX_SW_TRIP   = 14'h2016;
   localparam logic [IW-1:0] IDX_MODE      = 14'h2017;
   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int L8_DATA_BIT   = 0;
   localparam int L8_FUNC_BIT   = 1;
   localparam int IRQ_TRIP_BIT  = 0;
   localparam int IRQ_SYNC_BIT  = 1;
   localparam int MODE_RXSEL    = 4;
   localparam int RX_FIRST_LINE = 4;
   localparam int RX_SECOND_LINE = 2;
   localparam logic [NLOW-1:0] SELECT_RST  = 8'hFF;
   localparam logic [1:0]      DATA_L8_RST = 2'h2;
   localparam logic [NLOW-1:0] ZERO8       = 8'h00;
   localparam logic [1:0]      ZERO2       = 2'h0;
   localparam logic [DW-1:0]   ZERO32      = 32'h0000_0000;
endpackage

// >>> hw/piocip_port.sv
// Nine-line I/O port with change interrupts and peripheral interrupt merge
//
// Function
// - Select register bit n gives line n to general I/O when set, else alternate.
// - Power-on reset sets all select bits so lines start as general I/O.
// - Line eight function comes from bit 1 of its data register.
// - Direction registers: cleared bit input, set bit output, nine lines.
// - Any reset clears both direction registers.
// - Data reads return pin levels on input lines and the driven value on output lines; writes drive output lines.
// - Line interrupts need general I/O, enable bit set, and input direction.
// - Both rising and falling transitions count as events.
// - An event sets its change flag and raises the common I/O interrupt.
// - Reading a change flag register returns flags then clears them.
// - Any reset clears both interrupt enable registers.
// - Mode bit 4 picks receive pin; the unused receive line is free I/O.
// - I/O, sync and trip requests merge onto one peripheral interrupt.
// - A rising sync pulse raises the sync interrupt.
// - Trip pin fall, overcurrent, or software trip write raises trip.
// - Active-low interrupt line held while any latched request stays pending.
// - Reading peripheral flags clears trip and sync flags as acknowledgement.
`timescale 1ns/100ps
module piocip_port
   import piocip_pkg::*;
(
   input  wire logic                         i_clk,
   input  wire logic                         i_resetn,
   input  wire logic                         i_psel,
   input  wire logic                         i_penable,
   input  wire logic                         i_pwrite,
   input  wire logic [piocip_pkg::AW-1:0]    i_paddr,
   input  wire logic [piocip_pkg::DW-1:0]    i_pwdata,
   output logic      [piocip_pkg::DW-1:0]    o_prdata,
   output logic                              o_pready,
   output logic                              o_pslverr,
   input  wire logic [piocip_pkg::NLINES-1:0] i_pin,
   output logic      [piocip_pkg::NLINES-1:0] o_pin,
   output logic      [piocip_pkg::NLINES-1:0] o_pin_oe,
   input  wire logic [piocip_pkg::NLINES-1:0] i_alt_out,
   input  wire logic [piocip_pkg::NLINES-1:0] i_alt_oe,
   output logic      [piocip_pkg::NLINES-1:0] o_alt_in,
   output logic                              o_serial_rx,
   input  wire logic                         i_pwm_sync_pulse,
   input  wire logic                         i_pwm_trip_n,
   input  wire logic                         i_overcurrent,
   output logic                              o_io_irq,
   output logic                              o_periph_irq_n
);
   import piocip_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [NLOW-1:0]   select_r;
   logic [1:0]        data_l8_r;
   logic [NLOW-1:0]   dir_low_r;
   logic              dir_l8_r;
   logic [NLOW-1:0]   out_low_r;
   logic [NLOW-1:0]   inten_low_r;
   logic              inten_l8_r;
   logic [NLINES-1:0] flags_r;
   logic [NLINES-1:0] flags_nxt;
   logic [1:0]        irqf_r;
   logic [1:0]        irqf_nxt;
   logic [DW-1:0]     rdata_r;
   logic [NLINES-1:0] meta_r;
   logic [NLINES-1:0] sync_r;
   logic [NLINES-1:0] prev_r;
   logic [7:0]        mode_r;
   logic              psync_prev_r;
   logic              trip_prev_r;
   logic              ocur_prev_r;
   logic              irq_n_r;
   logic [NLINES-1:0] func;
   logic [NLINES-1:0] dir;
   logic [NLINES-1:0] outv;
   logic [NLINES-1:0] inten;
   logic [NLINES-1:0] src_en;
   logic [NLINES-1:0] change;
   logic [NLINES-1:0] rd_levels;
   logic              setup;
   logic              access;
   logic              wr;
   logic              rd;
   logic              mapped;
   logic              sync_evt;
   logic              trip_evt;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [AW-1:0] addr,
                                input logic [IW-1:0] idx);
      hit = (addr[AW-1:2] == idx) && (addr[1:0] == 2'h0);
   endfunction

   assign setup  = i_psel && !i_penable;
   assign access = i_psel && i_penable;
   assign mapped = hit(i_paddr, IDX_DIR_LOW)   || hit(i_paddr, IDX_DATA_LOW)
                || hit(i_paddr, IDX_INTEN_LOW) || hit(i_paddr, IDX_FLAG_LOW)
                || hit(i_paddr, IDX_SELECT)    || hit(i_paddr, IDX_DATA_L8)
                || hit(i_paddr, IDX_DIR_L8)    || hit(i_paddr, IDX_INTEN_L8)
                || hit(i_paddr, IDX_FLAG_L8)   || hit(i_paddr, IDX_IRQFLAGS)
                || hit(i_paddr, IDX_SW_TRIP)   || hit(i_paddr, IDX_MODE);
   assign wr     = access && i_pwrite && mapped;
   assign rd     = access && !i_pwrite && mapped;

   // Zero wait states; unmapped or misaligned addresses answer with an error
   assign o_pready  = 1'b1;
   assign o_pslverr = access && !mapped;
   assign o_prdata  = rdata_r;

   // ------------------------------------------------------------
   // Per-line views
   // ------------------------------------------------------------
   assign func   = {data_l8_r[L8_FUNC_BIT], select_r};
   assign dir    = {dir_l8_r, dir_low_r};
   assign outv   = {data_l8_r[L8_DATA_BIT], out_low_r};
   assign inten  = {inten_l8_r, inten_low_r};
   assign src_en = func & inten & ~dir;
   assign change = sync_r ^ prev_r;
   // Output lines read back the driven value, inputs the pin level
   assign rd_levels = (dir & outv) | (~dir & sync_r);

   // ------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------
   // Two stages guard against metastable pin levels; prev_r gives one flag per edge
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         meta_r <= {NLINES{1'b0}};
         sync_r <= {NLINES{1'b0}};
         prev_r <= {NLINES{1'b0}};
      end else begin
         meta_r <= i_pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         select_r    <= SELECT_RST;
         data_l8_r   <= DATA_L8_RST;
         dir_low_r   <= ZERO8;
         dir_l8_r    <= 1'b0;
         out_low_r   <= ZERO8;
         inten_low_r <= ZERO8;
         inten_l8_r  <= 1'b0;
         mode_r      <= ZERO8;
      end else if (wr) begin
         if (hit(i_paddr, IDX_SELECT)) begin
            select_r <= i_pwdata[NLOW-1:0];
         end
         if (hit(i_paddr, IDX_DATA_L8)) begin
            data_l8_r <= i_pwdata[1:0];
         end
         if (hit(i_paddr, IDX_DIR_LOW)) begin
            dir_low_r <= i_pwdata[NLOW-1:0];
         end
         if (hit(i_paddr, IDX_DIR_L8)) begin
            dir_l8_r <= i_pwdata[0];
         end
         if (hit(i_paddr, IDX_DATA_LOW)) begin
            out_low_r <= i_pwdata[NLOW-1:0];
         end
         if (hit(i_paddr, IDX_INTEN_LOW)) begin
            inten_low_r <= i_pwdata[NLOW-1:0];
         end
         if (hit(i_paddr, IDX_INTEN_L8)) begin
            inten_l8_r <= i_pwdata[0];
         end
         if (hit(i_paddr, IDX_MODE)) begin
            mode_r <= i_pwdata[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Read data, captured in the setup cycle
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_r <= ZERO32;
      end else if (setup && !i_pwrite) begin
         rdata_r <= ZERO32;
         if (hit(i_paddr, IDX_SELECT))    rdata_r[NLOW-1:0] <= select_r;
         if (hit(i_paddr, IDX_DATA_L8))   rdata_r[1:0] <= {data_l8_r[L8_FUNC_BIT], rd_levels[L8]};
         if (hit(i_paddr, IDX_DIR_LOW))   rdata_r[NLOW-1:0] <= dir_low_r;
         if (hit(i_paddr, IDX_DIR_L8))    rdata_r[0] <= dir_l8_r;
         if (hit(i_paddr, IDX_DATA_LOW))  rdata_r[NLOW-1:0] <= rd_levels[NLOW-1:0];
         if (hit(i_paddr, IDX_INTEN_LOW)) rdata_r[NLOW-1:0] <= inten_low_r;
         if (hit(i_paddr, IDX_INTEN_L8))  rdata_r[0] <= inten_l8_r;
         if (hit(i_paddr, IDX_FLAG_LOW))  rdata_r[NLOW-1:0] <= flags_r[NLOW-1:0];
         if (hit(i_paddr, IDX_FLAG_L8))   rdata_r[0] <= flags_r[L8];
         if (hit(i_paddr, IDX_IRQFLAGS))  rdata_r[1:0] <= irqf_r;
         if (hit(i_paddr, IDX_MODE))      rdata_r[7:0] <= mode_r;
      end
   end

   // ------------------------------------------------------------
   // Change flags
   // ------------------------------------------------------------
   // Only the bits reported in the setup cycle are cleared, so an event that
   // lands between setup and access, or on the access edge, is kept.
   always_comb begin
      flags_nxt = flags_r;
      if (rd && hit(i_paddr, IDX_FLAG_LOW)) begin
         flags_nxt[NLOW-1:0] = flags_r[NLOW-1:0] & ~rdata_r[NLOW-1:0];
      end
      if (rd && hit(i_paddr, IDX_FLAG_L8)) begin
         flags_nxt[L8] = flags_r[L8] & ~rdata_r[0];
      end
      flags_nxt = flags_nxt | (change & src_en);
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         flags_r <= {NLINES{1'b0}};
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // ------------------------------------------------------------
   // Sync and trip sources
   // ------------------------------------------------------------
   assign sync_evt = i_pwm_sync_pulse && !psync_prev_r;
   assign trip_evt = (trip_prev_r && !i_pwm_trip_n)
                  || (i_overcurrent && !ocur_prev_r)
                  || (wr && hit(i_paddr, IDX_SW_TRIP));

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         psync_prev_r <= 1'b0;
         // Trip pin idles high; a high reset value makes a pin already low at reset release count as a trip edge
         trip_prev_r  <= 1'b1;
         ocur_prev_r  <= 1'b0;
      end else begin
         psync_prev_r <= i_pwm_sync_pulse;
         trip_prev_r  <= i_pwm_trip_n;
         ocur_prev_r  <= i_overcurrent;
      end
   end

   always_comb begin
      irqf_nxt = irqf_r;
      if (rd && hit(i_paddr, IDX_IRQFLAGS)) begin
         irqf_nxt = irqf_r & ~rdata_r[1:0];
      end
      if (trip_evt) irqf_nxt[IRQ_TRIP_BIT] = 1'b1;
      if (sync_evt) irqf_nxt[IRQ_SYNC_BIT] = 1'b1;
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irqf_r <= ZERO2;
      end else begin
         irqf_r <= irqf_nxt;
      end
   end

   // ------------------------------------------------------------
   // Interrupt outputs
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_n_r <= 1'b1;
      end else begin
         irq_n_r <= !((|flags_r) || (|irqf_r));
      end
   end

   assign o_io_irq       = |flags_r;
   assign o_periph_irq_n = irq_n_r;

   // ------------------------------------------------------------
   // Pin drivers and alternate-function routing
   // ------------------------------------------------------------
   // Registered so a select write cannot glitch the pins between functions
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pin       <= {NLINES{1'b0}};
         o_pin_oe    <= {NLINES{1'b0}};
         o_alt_in    <= {NLINES{1'b0}};
         o_serial_rx <= 1'b0;
      end else begin
         o_pin       <= (func & outv) | (~func & i_alt_out);
         o_pin_oe    <= (func & dir) | (~func & i_alt_oe);
         o_alt_in    <= sync_r;
         // Receive pin choice; the other receive line stays usable as I/O
         o_serial_rx <= mode_r[MODE_RXSEL] ? sync_r[RX_SECOND_LINE]
                                           : sync_r[RX_FIRST_LINE];
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   localparam int WATCH_LINE = 4;   // A line that the bench uses as an interrupt source
   property p_oe_dir;
      @(posedge i_clk) disable iff (!i_resetn)
      (func[0] && dir[0]) |=> o_pin_oe[0];
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("output line not enabled");

   property p_alt_route;
      @(posedge i_clk) disable iff (!i_resetn)
      !func[3] |=> (o_pin[3] == $past(i_alt_out[3]));
   endproperty
   a_alt_route: assert property (p_alt_route) else $error("alternate output not routed");

   property p_flag_set;
      @(posedge i_clk) disable iff (!i_resetn)
      (change[WATCH_LINE] && src_en[WATCH_LINE]) |=> flags_r[WATCH_LINE] ##1 !o_periph_irq_n;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("change not flagged");

   property p_flag_src;
      @(posedge i_clk) disable iff (!i_resetn)
      $rose(flags_r[L8]) |-> $past(src_en[L8] && change[L8]);
   endproperty
   a_flag_src: assert property (p_flag_src) else $error("flag from disabled line");

   property p_flag_clr;
      @(posedge i_clk) disable iff (!i_resetn)
      (rd && hit(i_paddr, IDX_FLAG_LOW) && !(|(change & src_en))
          && ((flags_r[NLOW-1:0] & ~rdata_r[NLOW-1:0]) == ZERO8))
         |=> (flags_r[NLOW-1:0] == ZERO8);
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared by read");

   property p_sync_irq;
      @(posedge i_clk) disable iff (!i_resetn)
      (i_pwm_sync_pulse && !psync_prev_r) |=> irqf_r[IRQ_SYNC_BIT] ##1 !o_periph_irq_n;
   endproperty
   a_sync_irq: assert property (p_sync_irq) else $error("sync edge missed");

   property p_sw_trip;
      @(posedge i_clk) disable iff (!i_resetn)
      (wr && hit(i_paddr, IDX_SW_TRIP)) |=> irqf_r[IRQ_TRIP_BIT];
   endproperty
   a_sw_trip: assert property (p_sw_trip) else $error("software trip missed");

   property p_ack;
      @(posedge i_clk) disable iff (!i_resetn)
      (rd && hit(i_paddr, IDX_IRQFLAGS) && !sync_evt && !trip_evt && !(|flags_r)
          && !(|(change & src_en)) && ((irqf_r & ~rdata_r[1:0]) == ZERO2))
         |=> (irqf_r == ZERO2) ##1 o_periph_irq_n;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge did not release line");

   property p_hold;
      @(posedge i_clk) disable iff (!i_resetn)
      (|irqf_r) |=> !o_periph_irq_n;
   endproperty
   a_hold: assert property (p_hold) else $error("pending request not signalled");

   property p_rx_sel;
      @(posedge i_clk) disable iff (!i_resetn)
      mode_r[MODE_RXSEL] |=> (o_serial_rx == $past(sync_r[RX_SECOND_LINE]));
   endproperty
   a_rx_sel: assert property (p_rx_sel) else $error("second receive pin not selected");

   c_pio_irq:  cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_io_irq));
   c_trip_pin: cover property (@(posedge i_clk) disable iff (!i_resetn) $fell(i_pwm_trip_n) ##1 irqf_r[0]);
   c_flag_rd:  cover property (@(posedge i_clk) disable iff (!i_resetn) rd && hit(i_paddr, IDX_FLAG_L8));
   c_sync_irq: cover property (@(posedge i_clk) disable iff (!i_resetn) sync_evt ##1 irqf_r[IRQ_SYNC_BIT]);
   c_sw_trip:  cover property (@(posedge i_clk) disable iff (!i_resetn) wr && hit(i_paddr, IDX_SW_TRIP));
endmodule

// >>> tb/piocip_ext.sv
// Model of the external circuitry on the nine I/O lines
`timescale 1ns/100ps
module piocip_ext (
   input  wire logic [8:0] i_drive_en,
   input  wire logic [8:0] i_drive_val,
   input  wire logic [8:0] i_dut_oe,
   input  wire logic [8:0] i_dut_val,
   output logic      [8:0] o_level
);
   // ------------------------------------------------------------
   // Line resolution
   // ------------------------------------------------------------
   // Each line has a pull-down, so an undriven line reads low.
   // Two drivers on one line give an unknown, which any later comparison catches.
   always_comb begin
      for (int n = 0; n < 9; n++) begin
         if (i_dut_oe[n] && i_drive_en[n])
            o_level[n] = 1'bx;
         else if (i_dut_oe[n])
            o_level[n] = i_dut_val[n];
         else if (i_drive_en[n])
            o_level[n] = i_drive_val[n];
         else
            o_level[n] = 1'b0;
      end
   end
endmodule

// >>> tb/piocip_tb.sv
// Self-checking testbench for the nine-line I/O port
`timescale 1ns/100ps
module tb;
   import piocip_pkg::*;
   logic            i_clk, i_resetn, i_psel, i_penable, i_pwrite;
   logic [AW-1:0]   i_paddr;
   logic [DW-1:0]   i_pwdata, o_prdata, rd;
   logic            o_pready, o_pslverr, err_seen, o_serial_rx;
   logic [8:0]      i_pin, o_pin, o_pin_oe, i_alt_out, i_alt_oe, o_alt_in, ext_en, ext_val;
   logic            i_pwm_sync_pulse, i_pwm_trip_n, i_overcurrent, o_io_irq, o_periph_irq_n;
   int              errors, n_compared;

   piocip_port u_dut (
      .i_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
      .o_pslverr, .i_pin, .o_pin, .o_pin_oe, .i_alt_out, .i_alt_oe, .o_alt_in, .o_serial_rx,
      .i_pwm_sync_pulse, .i_pwm_trip_n, .i_overcurrent, .o_io_irq, .o_periph_irq_n
   );
   piocip_ext u_ext (
      .i_drive_en(ext_en), .i_drive_val(ext_val), .i_dut_oe(o_pin_oe), .i_dut_val(o_pin), .o_level(i_pin)
   );

   always #10 i_clk = ~i_clk;

   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Request held until pready is seen high; data taken at that same edge
   task automatic apb(input logic wr, input logic [IW-1:0] idx, input logic [31:0] wd);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= {idx, 2'b00};
      i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'b1;
      @(posedge i_clk);
      while (o_pready !== 1'b1)
         @(posedge i_clk);
      rd = o_prdata;
      err_seen = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [IW-1:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, ZERO32);
      check(rd, exp);
   endtask
   task automatic results;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      i_resetn = 1'b0;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = '0;
      i_pwdata = '0;
      i_alt_out = '0;
      i_alt_oe = '0;
      i_pwm_sync_pulse = 1'b0;
      i_pwm_trip_n = 1'b1;
      i_overcurrent = 1'b0;
      ext_en = 9'h1FF;
      ext_val = '0;
      errors = 0;
      n_compared = 0;
      cyc(4);
      i_resetn <= 1'b1;
      cyc(3);
      rd_chk(IDX_SELECT, 32'h0000_00FF);
      rd_chk(IDX_DIR_LOW, ZERO32);
      rd_chk(IDX_DIR_L8, ZERO32);
      rd_chk(IDX_INTEN_LOW, ZERO32);
      rd_chk(IDX_INTEN_L8, ZERO32);
      rd_chk(IDX_DATA_L8, 32'h0000_0002);
      check({23'h0, o_pin_oe}, ZERO32);
      // Mixed directions: outputs read back written data, inputs the pin level
      ext_en <= 9'h15A;
      ext_val <= 9'h050;
      apb(1'b1, IDX_DIR_LOW, 32'h0000_00A5);
      apb(1'b1, IDX_DATA_LOW, 32'h0000_00FF);
      cyc(4);
      check({23'h0, o_pin_oe}, 32'h0000_00A5);
      check({23'h0, o_pin & o_pin_oe}, 32'h0000_00A5);
      rd_chk(IDX_DATA_LOW, 32'h0000_00F5);
      ext_en <= 9'h05A;
      apb(1'b1, IDX_DIR_L8, 32'h0000_0001);
      apb(1'b1, IDX_DATA_L8, 32'h0000_0003);
      cyc(4);
      check({30'h0, o_pin_oe[8], o_pin[8]}, 32'h0000_0003);
      rd_chk(IDX_DATA_L8, 32'h0000_0003);
      apb(1'b1, IDX_DIR_L8, ZERO32);
      apb(1'b1, IDX_DATA_L8, 32'h0000_0002);
      apb(1'b1, IDX_DIR_LOW, 32'h0000_0040);
      // Serial port owns lines 0-3 and 5; line 3 as an external serial clock
      ext_en <= 9'h19C;
      ext_val <= 9'h004;
      i_alt_oe <= 9'h023;
      i_alt_out <= 9'h021;
      apb(1'b1, IDX_SELECT, 32'h0000_00D0);
      rd_chk(IDX_SELECT, 32'h0000_00D0);
      cyc(4);
      check({23'h0, o_pin_oe}, 32'h0000_0063);
      check({23'h0, o_pin & 9'h023}, 32'h0000_0021);
      check({31'h0, o_alt_in[2]}, 32'h0000_0001);
      apb(1'b1, IDX_MODE, ZERO32);
      cyc(3);
      check({31'h0, o_serial_rx}, ZERO32);
      apb(1'b1, IDX_MODE, 32'h0000_0010);
      cyc(3);
      check({31'h0, o_serial_rx}, 32'h0000_0001);
      // Only lines in I/O function, enabled and input may flag
      apb(1'b1, IDX_INTEN_LOW, 32'h0000_00FF);
      for (int e = 0; e < 2; e++) begin
         ext_val <= ext_val ^ 9'h09F;
         cyc(6);
         check({30'h0, o_io_irq, o_periph_irq_n}, 32'h0000_0002);
         rd_chk(IDX_FLAG_LOW, 32'h0000_0090);
         rd_chk(IDX_FLAG_LOW, ZERO32);
      end
      // Line eight flags only in I/O function
      apb(1'b1, IDX_INTEN_L8, 32'h0000_0001);
      ext_val <= ext_val ^ 9'h100;
      cyc(6);
      rd_chk(IDX_FLAG_L8, 32'h0000_0001);
      apb(1'b1, IDX_DATA_L8, ZERO32);
      ext_val <= ext_val ^ 9'h100;
      cyc(6);
      rd_chk(IDX_FLAG_L8, ZERO32);
      apb(1'b1, IDX_DATA_L8, 32'h0000_0002);
      // Interrupt line stays low until both flag registers are read
      ext_val <= ext_val ^ 9'h110;
      cyc(6);
      rd_chk(IDX_FLAG_LOW, 32'h0000_0010);
      cyc(2);
      check({31'h0, o_periph_irq_n}, ZERO32);
      rd_chk(IDX_FLAG_L8, 32'h0000_0001);
      cyc(2);
      check({30'h0, o_io_irq, o_periph_irq_n}, 32'h0000_0001);
      // Sync and the three trip sources
      for (int k = 0; k < 4; k++) begin
         case (k)
            0: i_pwm_sync_pulse <= 1'b1;
            1: i_pwm_trip_n <= 1'b0;
            2: i_overcurrent <= 1'b1;
            default: apb(1'b1, IDX_SW_TRIP, 32'h0000_0001);
         endcase
         cyc(3);
         check({31'h0, o_periph_irq_n}, ZERO32);
         rd_chk(IDX_IRQFLAGS, (k == 0) ? 32'h0000_0002 : 32'h0000_0001);
         rd_chk(IDX_IRQFLAGS, ZERO32);
         i_pwm_sync_pulse <= 1'b0;
         i_pwm_trip_n <= 1'b1;
         i_overcurrent <= 1'b0;
         cyc(3);
         check({31'h0, o_periph_irq_n}, 32'h0000_0001);
      end
      // Unmapped word is refused
      apb(1'b0, 14'h2000, ZERO32);
      check(rd, ZERO32);
      check({30'h0, o_pready, err_seen}, 32'h0000_0003);
      results();
   end

   initial begin
      #100_000;
      errors++;
      results();
   end
endmodule
